// file: option_slot_consts.svh
// Constants for the option slot I/O write and DMA read port.
`ifndef OPTION_SLOT_CONSTS_SVH
`define OPTION_SLOT_CONSTS_SVH
`define AD_W 32
`define MASK_LSB 1
`define MASK_MSB 4
`define WADDR_LSB 5
`define WADDR_MSB 31
`define DEC_BITS 4
`define DMA_HI_MSB 4
`define LEN_W 7
`define MAX_WORDS 7'h40
`define BOUND_WORDS 12'h200
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define TIMEOUT_CYCLES 16'h07d0
`endif

// file: option_slot_fifo.sv
// Parameterised FIFO for DMA read words.
`timescale 1ns/1ps
module option_slot_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (clk_en) begin
         if (push) begin
            mem[wp_q] <= in_data;
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// file: option_slot_pkg.sv
// Types for the option slot I/O write and DMA read port.
package option_slot_pkg;
   typedef enum logic [2:0] {
      DMA_IDLE,
      DMA_REQ,
      DMA_ADDR,
      DMA_WAIT,
      DMA_DATA,
      DMA_FLUSH
   } dma_state_t;

   typedef struct packed {
      logic sel_n;
      logic write_n;
      logic ack_n;
      logic err_n;
   } ctl_in_t;

   typedef struct packed {
      logic [3:0] be;
      logic [3:0] index;
      logic [31:0] data;
   } io_word_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [6:0] words;
   } dma_cmd_t;
endpackage

// file: option_slot_port.sv
// Option slot I/O write slave and DMA read master.
// How it works
// - Mask bit one blocks that byte lane
// - Capture address on select, then decode
// - Data cycle repeats until ready given
// - Ready pulse captures data, clash optional
// - Ready drops in the idle cycle
// - Word address decoded from few low bits
// - Words are 32 bits, length capped
// - Read words accepted every cycle
// - Never both requests at once
// - Request held until grant seen
// - Request held one cycle per word
// - Address cycle carries 32-bit address
// - Transfers never cross 2048-byte boundary
// - Fault ends transfer next cycle
// - Stale grant after abort is ignored
// - Address after grant, capture on grant
// - One-word request drops during latency
// - Clash only with ready while selected
`timescale 1ns/1ps
`include "option_slot_consts.svh"
module option_slot_port (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [31:0] ad_in,
   output logic [31:0] ad_out,
   output logic ad_oe,
   input wire option_slot_pkg::ctl_in_t ctl_pin,
   output logic io_ready_n,
   output logic io_busy_clash_n,
   output logic dma_fetch_request_n,
   output logic dma_store_request_n,
   input wire logic io_wr_stall,
   output logic io_wr_valid,
   output option_slot_pkg::io_word_t io_wr_word,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire option_slot_pkg::dma_cmd_t cmd,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [31:0] rd_data,
   output logic dma_fault_seen,
   output logic dma_done
);
   import option_slot_pkg::*;

   // ****************************************
   // State.
   // ****************************************
   typedef struct packed {
      ctl_in_t c1;
      ctl_in_t c2;
      logic [31:0] a1;
      logic [31:0] a2;
      logic sel_seen;
      logic rdy;
      logic clash;
      io_word_t word;
      logic word_v;
      dma_state_t st;
      logic [6:0] left;
      logic [6:0] got;
      logic [31:0] addr;
      logic [31:0] aout;
      logic aoe;
      logic req;
      logic fault;
      logic done;
      logic served;
      logic [6:0] total;
   } state_t;

   state_t q;
   state_t d;
   logic fifo_in_ready;
   logic fifo_push;

   // Number of words allowed from an address before the 2048-byte boundary.
   function automatic logic [6:0] room(input logic [31:0] a, input logic [6:0] n);
      logic [11:0] r;
      logic [6:0] m;
      r = `BOUND_WORDS - {3'h0, a[`WADDR_LSB+8:`WADDR_LSB]};
      m = (n > `MAX_WORDS) ? `MAX_WORDS : n;
      room = (r < {5'h00, m}) ? r[6:0] : m;
   endfunction

   // ****************************************
   // Next state.
   // ****************************************
   always_comb begin
      d = q;
      d.c1 = ctl_pin;
      d.c2 = q.c1;
      d.a1 = ad_in;
      d.a2 = q.a1;
      d.word_v = 1'b0;
      d.fault = 1'b0;
      d.done = 1'b0;
      fifo_push = 1'b0;
      cmd_ready = 1'b0;
      // I/O write slave.
      if (q.c2.sel_n || q.c2.write_n) begin
         d.sel_seen = 1'b0;
         d.served = 1'b0;
         d.rdy = 1'b0;
         d.clash = 1'b0;
      end else if (!q.sel_seen) begin
         d.sel_seen = 1'b1;
         d.word.index = q.a2[`WADDR_LSB+`DEC_BITS-1:`WADDR_LSB];
         d.word.be = ~q.a2[`MASK_MSB:`MASK_LSB];
      end else if (!q.rdy && !q.served && !io_wr_stall) begin
         // One ready per selection; the late deselect must not trigger a second one.
         d.served = 1'b1;
         d.rdy = 1'b1;
         d.clash = (q.st != DMA_IDLE);
         d.word.data = q.a2;
         d.word_v = 1'b1;
      end else begin
         d.rdy = 1'b0;
         d.clash = 1'b0;
      end
      // DMA read master.
      case (q.st)
         DMA_IDLE: begin
            d.aoe = 1'b0;
            cmd_ready = 1'b1;
            if (cmd_valid && cmd.words != 7'h00) begin
               d.addr = cmd.addr;
               d.left = room(cmd.addr, cmd.words);
               d.total = room(cmd.addr, cmd.words);
               d.got = 7'h00;
               d.req = 1'b1;
               d.st = DMA_REQ;
            end
         end
         DMA_REQ: begin
            if (!q.c2.ack_n && fifo_in_ready) begin
               d.aoe = 1'b1;
               d.aout = {q.addr[31:5], q.addr[4:0]};
               d.left = q.left - 7'h01;
               d.req = (q.left != 7'h01);
               d.st = DMA_ADDR;
            end
         end
         DMA_ADDR: begin
            d.aoe = 1'b0;
            d.left = (q.left == 7'h00) ? 7'h00 : q.left - 7'h01;
            d.req = (q.left > 7'h01);
            d.st = DMA_WAIT;
         end
         DMA_WAIT, DMA_DATA: begin
            if (q.left != 7'h00) begin
               d.left = q.left - 7'h01;
               d.req = (q.left > 7'h01);
            end
            if (!q.c2.err_n) begin
               d.req = 1'b0;
               d.fault = 1'b1;
               d.st = DMA_FLUSH;
            end else if (!q.c2.ack_n) begin
               fifo_push = 1'b1;
               d.got = q.got + 7'h01;
               d.st = DMA_DATA;
               if (q.got + 7'h01 == q.total) begin
                  d.done = 1'b1;
                  d.req = 1'b0;
                  d.st = DMA_FLUSH;
               end
            end
         end
         default: begin
            d.req = 1'b0;
            if (q.c2.ack_n) begin
               d.st = DMA_IDLE;
            end
         end
      endcase
   end

   // ****************************************
   // Registers.
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         q <= '0;
         q.c1 <= 4'hf;
         q.c2 <= 4'hf;
         q.st <= DMA_IDLE;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // ****************************************
   // Read buffer.
   // ****************************************
   option_slot_fifo #(
      .WIDTH(`AD_W),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) read_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(q.a2),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // ****************************************
   // Outputs.
   // ****************************************
   assign ad_out = q.aout;
   assign ad_oe = q.aoe;
   assign io_ready_n = ~q.rdy;
   assign io_busy_clash_n = ~(q.clash && q.rdy);
   assign dma_fetch_request_n = ~q.req;
   assign dma_store_request_n = 1'b1;
   assign io_wr_valid = q.word_v;
   assign io_wr_word = q.word;
   assign dma_fault_seen = q.fault;
   assign dma_done = q.done;
endmodule

// file: option_slot_port_sva.sv
// Checker of the option slot port.
`timescale 1ns/1ps
module option_slot_port_sva (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire option_slot_pkg::ctl_in_t ctl_pin,
   input wire logic io_ready_n,
   input wire logic io_busy_clash_n,
   input wire logic dma_fetch_request_n,
   input wire logic dma_store_request_n,
   input wire logic ad_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence fault_s;
      !ctl_pin.err_n;
   endsequence
   sequence stop_s;
      ##[1:4] dma_fetch_request_n && !ad_oe;
   endsequence
   req_excl_a: assert property (dma_fetch_request_n || dma_store_request_n)
      else $error("both requests");
   ready_one_a: assert property (!io_ready_n |=> io_ready_n)
      else $error("ready too long");
   clash_only_a: assert property (io_ready_n |-> io_busy_clash_n)
      else $error("clash alone");
   ready_sel_a: assert property (!io_ready_n |-> !ctl_pin.sel_n && $past(!ctl_pin.sel_n, 2))
      else $error("ready unselected");
   drv_off_a: assert property (!ctl_pin.sel_n |-> !ad_oe)
      else $error("drive in write");
   req_hold_a: assert property ($fell(dma_fetch_request_n) |-> !dma_fetch_request_n[*3])
      else $error("request dropped");
   addr_once_a: assert property (ad_oe |=> !ad_oe)
      else $error("address long");
   fault_stop_a: assert property (fault_s |-> stop_s)
      else $error("fault ignored");
endmodule
bind option_slot_port option_slot_port_sva chk (.*);

// file: option_slot_port_tb.sv
// Self-checking bench of the option slot port.
`timescale 1ns/1ps
module option_slot_port_tb;
   import option_slot_pkg::*;
   logic sys_clk = 0, sys_rst = 1, clk_en = 1, cmd_valid = 0, rd_ready = 1;
   logic io_wr_stall = 0, ign = 0, fs = 0;
   logic io_ready_n, io_busy_clash_n, dma_fetch_request_n, dma_store_request_n, ad_oe;
   logic io_wr_valid, cmd_ready, rd_valid, dma_fault_seen, dma_done;
   logic [31:0] ad_in, ad_out, rd_data, ea, a, d;
   ctl_in_t ctl_pin;
   io_word_t io_wr_word;
   dma_cmd_t cmd = '0;
   io_word_t exp_io[$];
   logic [31:0] exp_rd[$];
   int fail_count = 0, compares = 0, cyc = 0, dn = 0;
   always #2.5 sys_clk = ~sys_clk;
   option_slot_port DUT (.*);
   option_slot_system sys (.*);
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      if (io_wr_valid) chk(io_wr_word, exp_io.pop_front());
      if (rd_valid && !ign) chk(rd_data, exp_rd.pop_front());
      if (ad_oe) chk(ad_out, ea);
      if (dma_fault_seen) fs = 1;
      if (dma_done) dn++;
      cyc++;
      if (cyc > 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic rd(input logic [31:0] adr, input int w, lat, fail);
      int k;
      int d0;
      d0 = dn;
      k = (w < 64) ? w : 64;
      if (512 - adr[13:5] < k) k = 512 - adr[13:5];
      ea = adr;
      ign = fail < k;
      if (!ign) for (int i = 0; i < k; i++) exp_rd.push_back(adr + i);
      @(negedge sys_clk);
      cmd_valid = 1;
      cmd = {adr, w[6:0]};
      do @(posedge sys_clk); while (cmd_ready !== 1'b1);
      @(negedge sys_clk);
      cmd_valid = 0;
      if (k > 0) sys.dma(ign ? fail + 3 : k, lat, fail, adr);
      else chk(dma_fetch_request_n, 1);
      repeat (40) @(negedge sys_clk);
      chk(dn - d0, (k > 0 && !ign) ? 1 : 0);
      ign = 0;
   endtask
   initial begin
      void'($urandom(76));
      fork
         forever begin
            @(negedge sys_clk);
            io_wr_stall = $urandom_range(3) == 0;
         end
      join_none
      repeat (16) @(negedge sys_clk);
      sys_rst = 0;
      for (int m = 0; m < 16; m++) begin
         a = $urandom;
         a[4:1] = m[3:0];
         d = $urandom;
         exp_io.push_back({~a[4:1], a[8:5], d});
         sys.io_write(a, d);
      end
      rd(32'h0000_1000, 1, 0, 99);
      rd(32'h0000_2005, 4, 5, 99);
      rd(32'h0001_0000, 100, 1, 99);
      rd(32'h0000_3f80, 8, 0, 99);
      rd(32'h0000_4000, 0, 0, 99);
      rd(32'h0000_5000, 6, 0, 2);
      chk(fs, 1);
      rd(32'h0000_6000, 3, 0, 99);
      chk(exp_rd.size() + exp_io.size(), 0);
      end_of_test();
   end
endmodule

// file: option_slot_system.sv
// System-side partner model.
`timescale 1ns/1ps
module option_slot_system (
   input wire logic sys_clk,
   input wire logic io_ready_n,
   input wire logic dma_fetch_request_n,
   output logic [31:0] ad_in,
   output option_slot_pkg::ctl_in_t ctl_pin
);
   int n;
   initial begin
      ad_in = 32'h0;
      ctl_pin = 4'hf;
   end
   task automatic io_write(input logic [31:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      ad_in = a;
      ctl_pin = 4'h3;
      @(negedge sys_clk);
      ad_in = d;
      n = 0;
      do @(posedge sys_clk); while (io_ready_n !== 1'b0 && n++ < 50);
      @(negedge sys_clk);
      ad_in = ~d;
      ctl_pin = 4'hf;
   endtask
   task automatic dma(input int w, lat, fail, input logic [31:0] b);
      n = 0;
      do @(posedge sys_clk); while (dma_fetch_request_n !== 1'b0 && n++ < 50);
      repeat (lat + 1) @(negedge sys_clk);
      ctl_pin.ack_n = 0;
      @(negedge sys_clk);
      ctl_pin.ack_n = 1;
      ad_in = ~ad_in;
      repeat (lat + 2) @(negedge sys_clk);
      for (int i = 0; i < w; i++) begin
         ad_in = b + i;
         ctl_pin.ack_n = 0;
         ctl_pin.err_n = i != fail;
         @(negedge sys_clk);
      end
      ad_in = ~ad_in;
      ctl_pin = 4'hf;
   endtask
endmodule
